// *** hw/spmp_port.sv ***
// byte-wide serial peripheral port, master or slave, with register port
//
// Overview of operation
// RQ1 - unselected slave leaves its slave-out data pin undriven.
// RQ2 - master mode: slave-out pin is input, master-out and clock pins drive.
// RQ3 - one shift register for send and receive; one done flag ends a byte.
// RQ4 - master holds master-out line high whenever no byte is moving.
// RQ5 - master puts each bit out half a clock period before its latch edge.
// RQ6 - both ends swap exactly one byte over eight clock pulses.
// RQ7 - slave clock is asynchronous; synchronise at byte boundaries only.
// RQ8 - rate bits have no effect in slave mode.
// RQ9 - master divides bus clock by 2, 4, 16 or 32 per rate bits.
// RQ10 - master clock samples slave-out input and shifts master-out data.
// RQ11 - the far master keeps select low from before first edge past eighth.
// RQ12 - select low puts first bit out per phase and blocks data writes.
// RQ13 - data write during a transfer raises the write collision flag.
// RQ14 - deselected slave ignores clock and master-out inputs.
// RQ15 - select low in master mode drops master and enable, sets mode fault.
// RQ16 - with irq enable set, done or mode fault raise an interrupt request.
// RQ17 - port enable hands the four serial pins over to this port.
// RQ18 - lsb-first select picks shift direction; clear means msb first.
// RQ19 - master select 0 is slave mode, 1 is master mode.
// RQ20 - polarity and phase pick one of four timings; both ends must match.
// RQ21 - done flag sets after eighth pulse; status read then data access clears.
// RQ22 - colliding data write is dropped, the byte in flight is kept.
// RQ23 - mode fault clears only by status read seeing it, then control write.
// RQ24 - data reads return a buffer loaded when the done flag sets.
// RQ25 - polarity sets clock idle level; phase picks first or second edge.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module spmp_port (
	input  wire logic       REF_CLK,    // bus clock, 100 MHz
	input  wire logic       RST,        // asynchronous reset, active high
	input  wire logic [1:0] ADDR,       // register index
	input  wire logic [7:0] WR_DATA,    // register write data
	input  wire logic       WR_EN,      // write strobe
	input  wire logic       RD_EN,      // read strobe
	output logic      [7:0] RD_DATA,    // read data, cycle after strobe
	input  wire logic       SCK_IN,     // serial clock pin level
	output logic            SCK_OUT,    // serial clock drive value
	output logic            SCK_OE,     // serial clock drive enable
	input  wire logic       MOSI_IN,    // master-out pin level
	output logic            MOSI_OUT,   // master-out drive value
	output logic            MOSI_OE,    // master-out drive enable
	input  wire logic       MISO_IN,    // slave-out pin level
	output logic            MISO_OUT,   // slave-out drive value
	output logic            MISO_OE,    // slave-out drive enable
	input  wire logic       SEL_N,      // slave select pin, active low
	output logic            PINS_OWNED, // port pins 2..5 given to this port
	output logic            IRQ         // interrupt request, level
);
	import spmp_pkg::*;

	logic [7:0]  ctrl;
	logic [7:0]  sh;
	logic [7:0]  rx_buf;
	logic        out_bit;
	logic [2:0]  bit_cnt;
	logic [4:0]  half_cnt;
	logic [4:0]  edge_cnt;
	logic        phase;
	spmp_state_e state;
	logic        done_flag, write_collision_flag_flag, mode_fault_flag_flag;
	logic        done_arm, write_collision_flag_arm, mode_fault_flag_arm;
	logic        sck_m, sck_s, sck_d;
	logic        mosi_m, mosi_s, miso_m, miso_s;
	logic        sel_m, sel_s, sel_d;
	logic [3:0]  cap_pipe, end_pipe;
	logic [2:0]  rx_cnt, tx_n, tx_pos;
	logic        m_busy, m_cap, take;

	function automatic logic top_bit(input logic lsb, input logic [7:0] x);
		top_bit = lsb ? x[0] : x[7];
	endfunction

	function automatic logic [7:0] shift_in(input logic lsb, input logic [7:0] x,
		input logic b);
		shift_in = lsb ? {b, x[7:1]} : {x[6:0], b};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// decode of control fields and bus strobes
	logic       master, port_en, clock_idle_polarity, clock_sample_phase, lsb;
	logic       ctrl_wr, stat_rd, data_wr, data_acc;
	assign master   = ctrl[CTRL_MASTER];   // [RQ19]
	assign port_en  = ctrl[CTRL_PORT_EN];
	assign clock_idle_polarity     = ctrl[CTRL_CLOCK_IDLE_POLARITY];
	assign clock_sample_phase     = ctrl[CTRL_CLOCK_SAMPLE_PHASE];
	assign lsb      = ctrl[CTRL_LSB_FIRST];
	assign ctrl_wr  = WR_EN && (ADDR == ADDR_CTRL);
	assign stat_rd  = RD_EN && (ADDR == ADDR_STAT);
	assign data_wr  = WR_EN && (ADDR == ADDR_DATA);
	assign data_acc = (WR_EN || RD_EN) && (ADDR == ADDR_DATA);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; only the second stage is ever looked at
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sck_m  <= 1'b0;
			sck_s  <= 1'b0;
			mosi_m <= 1'b1;
			mosi_s <= 1'b1;
			miso_m <= 1'b1;
			miso_s <= 1'b1;
			sel_m  <= 1'b1;
			sel_s  <= 1'b1;
		end else begin
			sck_m  <= SCK_IN;
			sck_s  <= sck_m;
			mosi_m <= MOSI_IN;
			mosi_s <= mosi_m;
			miso_m <= MISO_IN;
			miso_s <= miso_m;
			sel_m  <= SEL_N;
			sel_s  <= sel_m;
		end
	end

	// delayed copies for edge detection of the synchronised levels
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sck_d <= 1'b0;
			sel_d <= 1'b1;
		end else begin
			sck_d <= sck_s;
			sel_d <= sel_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slave side events; external clock is oversampled so the byte is
	// handed to the bus domain only when the count reaches eight
	logic selected, s_edge, s_lead, s_trail, sel_fall;
	assign selected = !master && port_en && !sel_s;           // [RQ14]
	assign s_edge   = selected && (sck_s != sck_d);           // [RQ7] [RQ8]
	assign s_lead   = s_edge && (sck_s != clock_idle_polarity);              // [RQ25]
	assign s_trail  = s_edge && (sck_s == clock_idle_polarity);
	assign sel_fall = selected && sel_d;

	////////////////////////////////////////////////////////////////////////
	// master side events; an edge every half period of the divided clock
	logic       fault, m_tick, m_lead, m_trail, m_last, start;
	logic [4:0] half;
	assign half    = spmp_half(ctrl[CTRL_RATE_HI:CTRL_RATE_LO]);   // [RQ9]
	assign fault   = master && port_en && !sel_s;                 // [RQ15]
	assign m_tick  = (state == SPMP_SHIFT) && (half_cnt == half - HALF_ONE);
	assign m_lead  = m_tick && !edge_cnt[0];
	assign m_trail = m_tick && edge_cnt[0];
	assign m_last  = m_tick && (edge_cnt == LAST_EDGE);          // [RQ6]
	assign start   = data_wr && master && port_en && !fault && !m_busy;
	// the byte stays busy until the last delayed sample has been taken
	assign m_busy  = (state != SPMP_IDLE) || (|end_pipe);
	assign m_cap   = clock_sample_phase ? m_trail : m_lead;
	// sh shifts late in master mode, so the next bit out is found by index:
	// bits launched so far against shifts already applied
	assign tx_n    = edge_cnt[3:1] + {2'h0, !clock_sample_phase};
	assign tx_pos  = lsb ? (tx_n - rx_cnt) : (LAST_BIT - tx_n + rx_cnt);

	////////////////////////////////////////////////////////////////////////
	// common shift events for both modes
	logic busy, lead, trail, capture, launch, in_bit, xfer_done, write_collision_flag_evt;
	assign busy      = master ? m_busy : selected;                 // [RQ12]
	assign take      = master ? cap_pipe[3] : capture;             // [RQ10]
	assign lead      = m_lead || s_lead;
	assign trail     = m_trail || s_trail;
	assign capture   = clock_sample_phase ? trail : lead;                        // [RQ20] [RQ25]
	assign launch    = clock_sample_phase ? lead : (trail || sel_fall);          // [RQ5] [RQ12]
	assign in_bit    = master ? miso_s : mosi_s;                   // [RQ2] [RQ10]
	assign xfer_done = master ? end_pipe[3] : (capture && (bit_cnt == LAST_BIT));
	assign write_collision_flag_evt  = data_wr && busy;                            // [RQ13]

	////////////////////////////////////////////////////////////////////////
	// control register; a mode fault overrides the master and enable bits of a write in the same cycle
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ctrl <= CTRL_RESET;
		end else begin
			if (ctrl_wr) begin
				ctrl <= WR_DATA;
			end
			if (fault) begin
				ctrl[CTRL_MASTER]  <= 1'b0;   // [RQ15]
				ctrl[CTRL_PORT_EN] <= 1'b0;   // [RQ15]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// master sequencer: sixteen edges per byte, aborted by a mode fault
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state    <= SPMP_IDLE;
			half_cnt <= 5'h00;
			edge_cnt <= 5'h00;
			phase    <= 1'b0;
		end else begin
			case (state)
				SPMP_IDLE: begin
					half_cnt <= 5'h00;
					edge_cnt <= 5'h00;
					phase    <= 1'b0;
					if (start) begin
						state <= SPMP_SHIFT;
					end
				end
				SPMP_SHIFT: begin
					if (fault || !master) begin
						state <= SPMP_IDLE;
					end else if (m_tick) begin
						half_cnt <= 5'h00;
						edge_cnt <= edge_cnt + 5'h01;
						phase    <= !phase;
						if (m_last) begin
							state <= SPMP_IDLE;
						end
					end else begin
						half_cnt <= half_cnt + 5'h01;
					end
				end
				default: state <= SPMP_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// master sampling ticks delayed by the pin round trip (registered clock
	// out, two synchroniser stages in); without it fast rates read stale bits
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			cap_pipe <= 4'h0;
			end_pipe <= 4'h0;
		end else if (fault || !master) begin
			cap_pipe <= 4'h0;
			end_pipe <= 4'h0;
		end else begin
			cap_pipe <= {cap_pipe[2:0], m_cap};    // [RQ10]
			end_pipe <= {end_pipe[2:0], m_last};   // [RQ6]
		end
	end

	// delayed master shifts applied so far in this byte
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			rx_cnt <= 3'h0;
		end else if (!m_busy) begin
			rx_cnt <= 3'h0;
		end else if (master && take) begin
			rx_cnt <= rx_cnt + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared shift register; a colliding write is simply not taken
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sh <= BYTE_ZERO;
		end else if (data_wr && !busy) begin
			sh <= WR_DATA;                        // [RQ22]
		end else if (take) begin
			sh <= shift_in(lsb, sh, in_bit);      // [RQ3] [RQ18]
		end
	end

	// outgoing bit stays put between launch events
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			out_bit <= 1'b1;
		end else if (data_wr && !busy) begin
			out_bit <= top_bit(lsb, WR_DATA);     // [RQ5]
		end else if (launch) begin
			out_bit <= master ? sh[tx_pos] : top_bit(lsb, sh);   // [RQ18]
		end
	end

	// slave bit count restarts whenever select goes away
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			bit_cnt <= 3'h0;
		end else if (!selected || start) begin
			bit_cnt <= 3'h0;
		end else if (capture) begin
			bit_cnt <= bit_cnt + 3'h1;            // [RQ6]
		end
	end

	// receive buffer loads in the cycle the done flag is raised
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			rx_buf <= BYTE_ZERO;
		end else if (xfer_done) begin
			rx_buf <= take ? shift_in(lsb, sh, in_bit) : sh;   // [RQ24]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky flags: set wins over the two-step clear
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			done_flag <= 1'b0;
			done_arm  <= 1'b0;
		end else begin
			if (stat_rd) begin
				done_arm <= done_flag;
			end else if (data_acc) begin
				done_arm <= 1'b0;
			end
			if (xfer_done) begin
				done_flag <= 1'b1;                // [RQ21] [RQ3]
			end else if (data_acc && done_arm) begin
				done_flag <= 1'b0;                // [RQ21]
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			write_collision_flag_flag <= 1'b0;
			write_collision_flag_arm  <= 1'b0;
		end else begin
			if (stat_rd) begin
				write_collision_flag_arm <= write_collision_flag_flag;
			end else if (data_acc) begin
				write_collision_flag_arm <= 1'b0;
			end
			if (write_collision_flag_evt) begin
				write_collision_flag_flag <= 1'b1;                // [RQ13]
			end else if (data_acc && write_collision_flag_arm) begin
				write_collision_flag_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			mode_fault_flag_flag <= 1'b0;
			mode_fault_flag_arm  <= 1'b0;
		end else begin
			if (stat_rd) begin
				mode_fault_flag_arm <= mode_fault_flag_flag;
			end else if (ctrl_wr) begin
				mode_fault_flag_arm <= 1'b0;
			end
			if (fault) begin
				mode_fault_flag_flag <= 1'b1;                // [RQ15]
			end else if (ctrl_wr && mode_fault_flag_arm) begin
				mode_fault_flag_flag <= 1'b0;                // [RQ23]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe; unmapped index reads zero
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			RD_DATA <= BYTE_ZERO;
		end else if (RD_EN) begin
			if (ADDR == ADDR_CTRL) begin
				RD_DATA <= ctrl;
			end else if (ADDR == ADDR_STAT) begin
				RD_DATA <= {done_flag, write_collision_flag_flag, 1'b0, mode_fault_flag_flag, 4'h0};
			end else if (ADDR == ADDR_DATA) begin
				RD_DATA <= rx_buf;                // [RQ24]
			end else begin
				RD_DATA <= BYTE_ZERO;
			end
		end
	end

	// interrupt request; masked in this port by the irq enable bit of the control register
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= ctrl[CTRL_IRQ_EN] && (done_flag || mode_fault_flag_flag);   // [RQ16]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers, all registered; clock and data share the same delay so
	// their half-period relation is kept at the pins
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			SCK_OUT    <= 1'b0;
			SCK_OE     <= 1'b0;
			MOSI_OUT   <= 1'b1;
			MOSI_OE    <= 1'b0;
			MISO_OUT   <= 1'b1;
			MISO_OE    <= 1'b0;
			PINS_OWNED <= 1'b0;
		end else begin
			SCK_OUT    <= clock_idle_polarity ^ (phase && (state == SPMP_SHIFT));   // [RQ25]
			SCK_OE     <= master && port_en && !fault;              // [RQ2]
			MOSI_OUT   <= m_busy ? out_bit : 1'b1;                  // [RQ4] [RQ5]
			MOSI_OE    <= master && port_en && !fault;              // [RQ2]
			MISO_OUT   <= out_bit;
			MISO_OE    <= selected;                                 // [RQ1]
			PINS_OWNED <= port_en && !fault;                        // [RQ17]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_miso_hiz;
		@(posedge REF_CLK) disable iff (RST)
		(!master && sel_s) |=> !MISO_OE;
	endproperty
	a_miso_hiz: assert property (p_miso_hiz) else $error("slave-out driven while deselected"); // [RQ1]

	property p_master_pins;
		@(posedge REF_CLK) disable iff (RST)
		(master && port_en && sel_s) |=> (SCK_OE && MOSI_OE && !MISO_OE);
	endproperty
	a_master_pins: assert property (p_master_pins) else $error("master pin roles wrong"); // [RQ2]

	property p_idle_high;
		@(posedge REF_CLK) disable iff (RST)
		!m_busy |=> MOSI_OUT;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("master-out not high at idle"); // [RQ4]

	property p_div4;
		@(posedge REF_CLK) disable iff (RST)
		(m_tick && !m_last && ctrl[1:0] == 2'h1 && !fault) |=> !m_tick ##1 (m_tick || fault);
	endproperty
	a_div4: assert property (p_div4) else $error("divide-by-4 spacing wrong"); // [RQ9]

	property p_byte_len;
		@(posedge REF_CLK) disable iff (RST)
		(start && ctrl[1:0] == 2'h0) |-> ##[1:20] (xfer_done || fault || !master);
	endproperty
	a_byte_len: assert property (p_byte_len) else $error("byte not done in time"); // [RQ6]

	property p_write_collision_flag;
		@(posedge REF_CLK) disable iff (RST)
		(data_wr && busy && !take) |=> (write_collision_flag_flag && sh == $past(sh));
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged or write taken"); // [RQ22]

	property p_fault;
		@(posedge REF_CLK) disable iff (RST)
		fault |=> (!master && !port_en && mode_fault_flag_flag && state == SPMP_IDLE);
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault not handled"); // [RQ15]

	property p_done;
		@(posedge REF_CLK) disable iff (RST)
		xfer_done |=> (done_flag && rx_buf == sh);
	endproperty
	a_done: assert property (p_done) else $error("done flag or buffer wrong"); // [RQ24]

	property p_mode_fault_flag_hold;
		@(posedge REF_CLK) disable iff (RST)
		(mode_fault_flag_flag && !mode_fault_flag_arm) |=> mode_fault_flag_flag;
	endproperty
	a_mode_fault_flag_hold: assert property (p_mode_fault_flag_hold) else $error("mode fault cleared early"); // [RQ23]

	property p_irq;
		@(posedge REF_CLK) disable iff (RST)
		(ctrl[CTRL_IRQ_EN] && (done_flag || mode_fault_flag_flag)) |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised"); // [RQ16]

	property p_slave_idle;
		@(posedge REF_CLK) disable iff (RST)
		!master |=> (state == SPMP_IDLE);
	endproperty
	a_slave_idle: assert property (p_slave_idle) else $error("master sequencer in slave mode"); // [RQ19]

	c_master_byte: cover property (@(posedge REF_CLK) disable iff (RST) master && xfer_done);
	c_slave_byte:  cover property (@(posedge REF_CLK) disable iff (RST) !master && xfer_done);
	c_fault:       cover property (@(posedge REF_CLK) disable iff (RST) fault);
	c_collision:   cover property (@(posedge REF_CLK) disable iff (RST) write_collision_flag_evt);
endmodule // spmp_port
`default_nettype wire

// *** shared/spmp_pkg.sv ***
// shared constants, types and helpers of the serial peripheral port
`default_nettype none
package spmp_pkg;
	// register map (word index on the plain register port)
	localparam logic [1:0] ADDR_CTRL      = 2'h0;
	localparam logic [1:0] ADDR_STAT      = 2'h1;
	localparam logic [1:0] ADDR_DATA      = 2'h2;
	// control register fields
	localparam int         CTRL_IRQ_EN    = 7;
	localparam int         CTRL_PORT_EN   = 6;
	localparam int         CTRL_LSB_FIRST = 5;
	localparam int         CTRL_MASTER    = 4;
	localparam int         CTRL_CLOCK_IDLE_POLARITY      = 3;
	localparam int         CTRL_CLOCK_SAMPLE_PHASE      = 2;
	localparam int         CTRL_RATE_HI   = 1;
	localparam int         CTRL_RATE_LO   = 0;
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	// status register fields
	localparam int         STAT_DONE      = 7;
	localparam int         STAT_WRITE_COLLISION_FLAG      = 6;
	localparam int         STAT_MODE_FAULT_FLAG      = 4;
	// byte framing: eight clock pulses, sixteen serial clock edges
	localparam logic [2:0] LAST_BIT       = 3'h7;
	localparam logic [4:0] LAST_EDGE      = 5'h0F;
	// half serial clock period in bus clocks for divisors 2, 4, 16, 32
	localparam logic [4:0] HALF_DIV2      = 5'h01;
	localparam logic [4:0] HALF_DIV4      = 5'h02;
	localparam logic [4:0] HALF_DIV16     = 5'h08;
	localparam logic [4:0] HALF_DIV32     = 5'h10;
	localparam logic [4:0] HALF_ONE       = 5'h01;
	localparam logic [7:0] BYTE_ZERO      = 8'h00;

	typedef enum logic {SPMP_IDLE, SPMP_SHIFT} spmp_state_e;

	// half period for the two rate bits
	function automatic logic [4:0] spmp_half(input logic [1:0] rate);
		case (rate)
			2'h0:    spmp_half = HALF_DIV2;
			2'h1:    spmp_half = HALF_DIV4;
			2'h2:    spmp_half = HALF_DIV16;
			default: spmp_half = HALF_DIV32;
		endcase
	endfunction
endpackage
`default_nettype wire

// *** verif/spmp_far_slave.sv ***
// far-side serial slave model, used while the port under test is master
`timescale 1ns/1ns
`default_nettype none
module spmp_far_slave (
	input  wire logic       sck,  // serial clock wire
	input  wire logic       mosi, // master-out wire
	input  wire logic       sel,  // selected by the bench
	input  wire logic       clock_idle_polarity, // clock idle level
	input  wire logic       clock_sample_phase, // sample on the second edge when set
	input  wire logic       lsb,  // least significant bit first
	input  wire logic [7:0] tx,   // byte sent back
	output logic            miso, // slave-out drive
	output logic      [7:0] rx    // byte received
);
	int   cnt;
	logic lead;

	function automatic logic tx_bit(input int i);
		tx_bit = lsb ? tx[i] : tx[7 - i];
	endfunction

	initial miso = 1'b1;
	//////////////////////////////////////////////////////////////////////////
	// released line shows the inverse of its last bit, so no held value can pass
	always @(sel) begin
		cnt = 0;
		miso = sel ? tx_bit(0) : ~miso;
	end

	// sample and shift on opposite edges, the phase picking which is first
	always @(sck) begin
		if (sel) begin
			lead = (sck != clock_idle_polarity);
			if (lead != clock_sample_phase) begin
				rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
				cnt = cnt + 1;
			end else if (cnt < 8) begin
				miso = tx_bit(cnt);
			end
		end
	end
endmodule // spmp_far_slave
`default_nettype wire

// *** verif/spmp_port_test.sv ***
// self-checking bench of the serial peripheral port
`timescale 1ns/1ns
`default_nettype none
module spmp_port_test;
	import spmp_pkg::*;
	logic       ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
	logic [1:0] addr    = 2'h0;
	logic [7:0] wr_data = 8'h00, p_tx = 8'h00, rd_data, p_rx;
	logic       tb_sck  = 1'b0, tb_mosi = 1'b1, sel_n = 1'b1, p_sel = 1'b0;
	logic       p_clock_idle_polarity  = 1'b0, p_clock_sample_phase = 1'b0, p_lsb = 1'b0, sck_d = 1'b0, rd_d = 1'b0;
	logic       sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, pins_owned, irq, p_miso;
	wire logic  sck_w   = sck_oe ? sck_out : tb_sck;
	wire logic  mosi_w  = mosi_oe ? mosi_out : tb_mosi;
	wire logic  miso_w  = miso_oe ? miso_out : p_miso;
	int         n_fail  = 0, compares = 0, seed = 79, cyc = 0, n_edge = 0, first = 0, last = 0;
	logic [7:0] exp_q[$];

	always #5 ref_clk = ~ref_clk;

	spmp_port i_spmp_port (
		.REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WR_DATA(wr_data),
		.WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
		.SCK_IN(sck_w), .SCK_OUT(sck_out), .SCK_OE(sck_oe),
		.MOSI_IN(mosi_w), .MOSI_OUT(mosi_out), .MOSI_OE(mosi_oe),
		.MISO_IN(miso_w), .MISO_OUT(miso_out), .MISO_OE(miso_oe),
		.SEL_N(sel_n), .PINS_OWNED(pins_owned), .IRQ(irq)
	);
	spmp_far_slave i_spmp_far_slave (
		.sck(sck_w), .mosi(mosi_w), .sel(p_sel), .clock_idle_polarity(p_clock_idle_polarity), .clock_sample_phase(p_clock_sample_phase),
		.lsb(p_lsb), .tx(p_tx), .miso(p_miso), .rx(p_rx)
	);

	task automatic cmp_rd(input logic [7:0] e);
		compares++;
		if (rd_data !== e) begin
			n_fail++;
			$display("wrong value at %0t: read %h, expected %h", $time, rd_data, e);
		end
	endtask

	task automatic cmp_pin(input logic got, input logic e, input string what);
		compares++;
		if (got !== e) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////
	// watcher: read data checked in the cycle after the strobe; clock edges counted
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (rd_d) cmp_rd(exp_q.pop_front());
		rd_d <= rd_en;
		sck_d <= sck_out;
		if (sck_out !== sck_d) begin
			n_edge = n_edge + 1;
			last = cyc;
			if (n_edge == 1) first = cyc;
		end
	end

	// one access then an idle cycle, so no strobe is assigned twice at one edge
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back(e);
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(posedge ref_clk);
	endtask
	//////////////////////////////////////////////////////////////////////////
	// port as master against the far slave; k picks rate, order, polarity, phase
	task automatic mxfer(input logic [2:0] k);
		logic [7:0] ctl, d;
		int         hv;
		logic       coll;
		ctl = {k[0] ^ k[2], 1'b1, k[1], 1'b1, k[2], k[0], k[1:0]};
		hv = (k[1:0] == 2'h0) ? 1 : (k[1:0] == 2'h1) ? 2 : (k[1:0] == 2'h2) ? 8 : 16;
		coll = (k == 3'h0) || (k == 3'h6);
		d = 8'($random(seed));
		p_tx <= 8'($random(seed));
		p_clock_idle_polarity <= k[2];
		p_clock_sample_phase <= k[0];
		p_lsb <= k[1];
		wr(ADDR_CTRL, ctl);
		repeat (4) @(posedge ref_clk);
		cmp_pin(mosi_out & mosi_oe, 1'b1, "master-out idle level");
		cmp_pin(sck_oe & ~miso_oe, 1'b1, "master pin roles");
		cmp_pin(pins_owned, 1'b1, "pins not handed over");
		p_sel <= 1'b1;
		n_edge = 0;
		wr(ADDR_DATA, d);
		if (coll) wr(ADDR_DATA, ~d);
		for (int t = 0; t < 800 && n_edge < 16; t++) @(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
		p_sel <= 1'b0;
		cmp_pin(n_edge == 16, 1'b1, "clock edge count");
		cmp_pin(last - first == 15 * hv, 1'b1, "clock divider");
		cmp_pin(sck_out, k[2], "clock idle level");
		cmp_pin(irq, ctl[7], "interrupt request");
		cmp_pin(p_rx === d, 1'b1, "byte at far side");
		rd(ADDR_STAT, coll ? 8'hC0 : 8'h80);
		rd(ADDR_DATA, p_tx);
		rd(ADDR_STAT, 8'h00);
	endtask

	// port as slave; the bench plays the far master, each clock level six cycles
	task automatic sxfer(input logic [2:0] k);
		logic [7:0] m, s;
		logic       mb;
		m = 8'($random(seed));
		s = 8'($random(seed));
		tb_sck <= k[2];
		wr(ADDR_CTRL, {2'h3, k[1], 1'b0, k[2], k[0], 2'($random(seed))});
		for (int t = 0; t < 4; t++) begin
			tb_sck <= ~tb_sck;
			repeat (4) @(posedge ref_clk);
		end
		cmp_pin(miso_oe, 1'b0, "deselected slave-out driven");
		cmp_pin(sck_oe | mosi_oe, 1'b0, "slave pin roles");
		wr(ADDR_DATA, s);
		rd(ADDR_STAT, 8'h00);
		sel_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		cmp_pin(miso_oe, 1'b1, "selected slave-out idle");
		if (k == 3'h1) wr(ADDR_DATA, ~s);
		for (int b = 0; b < 8; b++) begin
			mb = k[1] ? m[b] : m[7 - b];
			if (!k[0]) tb_mosi <= mb;
			repeat (6) @(posedge ref_clk);
			tb_sck <= ~k[2];
			if (k[0]) tb_mosi <= mb;
			repeat (6) @(posedge ref_clk);
			cmp_pin(miso_out, k[1] ? s[b] : s[7 - b], "slave-out bit");
			tb_sck <= k[2];
		end
		repeat (8) @(posedge ref_clk);
		cmp_pin(irq, 1'b1, "slave done request");
		sel_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		cmp_pin(miso_oe, 1'b0, "released slave-out");
		rd(ADDR_STAT, (k == 3'h1) ? 8'hC0 : 8'h80);
		rd(ADDR_DATA, m);
	endtask
	//////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		cmp_pin(sck_oe | mosi_oe | miso_oe | pins_owned | irq, 1'b0, "reset pins");
		rd(ADDR_CTRL, CTRL_RESET);
		wr(ADDR_STAT, 8'hFF);
		wr(2'h3, 8'hFF);
		rd(ADDR_STAT, 8'h00);
		rd(2'h3, 8'h00);
		wr(ADDR_CTRL, 8'h5A);
		rd(ADDR_CTRL, 8'h5A);
		for (int i = 0; i < 8; i++) mxfer(3'(i));
		wr(ADDR_CTRL, 8'hD3);
		repeat (3) @(posedge ref_clk);
		cmp_pin(sck_oe, 1'b1, "master clock drive");
		sel_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		cmp_pin(sck_oe | mosi_oe | pins_owned, 1'b0, "fault pins");
		cmp_pin(irq, 1'b1, "fault request");
		sel_n <= 1'b1;
		rd(ADDR_CTRL, 8'h83);
		wr(ADDR_CTRL, 8'h80);
		rd(ADDR_STAT, 8'h10);
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_STAT, 8'h00);
		cmp_pin(irq, 1'b0, "request after clear");
		for (int i = 0; i < 8; i++) sxfer(3'(i));
		conclude();
	end

	// watchdog: all transfers need well under a tenth of this span
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_fail++;
		$display("wrong value at %0t: run did not finish", $time);
		conclude();
	end
endmodule // spmp_port_test
`default_nettype wire
